// ### logic/etc_top.sv
// APB register block and request gating for the trigger conditioner
// Function
// (RULE_01) External source 0 triggers per field 1:0: fall, rise, low or high.
// (RULE_02) External source 1 triggers per field 3:2, same four-way encoding.
// (RULE_03) Logic-array source 0 triggers per field 5:4, same encoding.
// (RULE_04) External source 2 triggers per field 7:6, same encoding.
// (RULE_05) External source 3 triggers per field 9:8, same encoding.
// (RULE_06) Logic-array source 1 triggers per field 11:10, same encoding.
// (RULE_07) Software leaves reserved bits of both registers unwritten.
// (RULE_08) Writing one to clear bit 13 drops pending external source 0.
// (RULE_09) Writing one to clear bit 16 drops pending external source 1.
// (RULE_10) Writing one to clear bit 17 drops pending logic-array source 0.
// (RULE_11) Writing one to clear bit 18 drops pending external source 2.
// (RULE_12) Writing one to clear bit 19 drops pending external source 3.
// (RULE_13) Writing one to clear bit 20 drops pending logic-array source 1.
// (RULE_14) A request reaches the controller only when its enable bit is set.
// (RULE_15) Inputs are synchronised; edges set a flag held until cleared.
// (RULE_16) Level sources pass straight through, unlatched, ignoring clear writes.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module etc_top
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] EXT_INT,
  input wire logic [1:0] LA_INT,
  output logic [etc_pkg::NSRC-1:0] IRQ_REQ,
  output logic [etc_pkg::NSRC-1:0] FIQ_REQ,
  output logic INT_OUT
);
  import etc_pkg::*;

  etc_src_if sif();

  etc_cond u_cond
  (
    .clk(MCLK),
    .rst(SRST),
    .cp(sif.cnd)
  );

  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic mapped;
  logic [11:0] trig_r;
  logic [11:0] trig_nxt;
  logic [5:0] nen_r;
  logic [5:0] nen_nxt;
  logic [5:0] fen_r;
  logic [5:0] fen_nxt;
  logic [5:0] stat_r;
  logic [5:0] stat_nxt;
  logic [5:0] mask_r;
  logic [5:0] mask_nxt;
  logic [5:0] cond_q_r;
  logic [5:0] cond_q_nxt;
  logic [5:0] irq_r;
  logic [5:0] irq_nxt;
  logic [5:0] fiq_r;
  logic [5:0] fiq_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic int_r;
  logic int_nxt;
  logic [5:0] events;

  // Source order follows the trigger field order
  assign sif.src = {LA_INT[1], EXT_INT[3], EXT_INT[2], LA_INT[0], EXT_INT[1], EXT_INT[0]};
  assign sif.sel = trig_r;

  // APB phases; zero wait states, so every access completes in one cycle
  assign setup = PSEL & ~PENABLE;
  assign acc_wr = PSEL & PENABLE & PWRITE;
  assign acc_rd = PSEL & PENABLE & ~PWRITE;
  assign mapped = PADDR inside {ADDR_TRIG, ADDR_CLR, ADDR_NEN, ADDR_FEN,
                                ADDR_STAT, ADDR_MASK, ADDR_SRC};
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = rdat_r;

  // Clear pulse lasts exactly the access cycle of a write [RULE_08] [RULE_09] [RULE_10]
  assign sif.clr = (acc_wr && PADDR == ADDR_CLR) ? clr_bits(PWDATA) : 6'h00; // [RULE_11]
  // Level sources ignore this pulse inside the conditioner [RULE_12] [RULE_13] [RULE_16]

  // New conditioned request is an event for the status register
  assign events = sif.cond & ~cond_q_r;

  // Register file next-state; hardware set wins over read-clear
  always_comb
  begin
    trig_nxt = trig_r;
    nen_nxt = nen_r;
    fen_nxt = fen_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    rdat_nxt = rdat_r;
    cond_q_nxt = sif.cond;
    if (acc_wr)
    begin
      unique case (PADDR)
        ADDR_TRIG: trig_nxt = PWDATA[TRIG_USED-1:0]; // Reserved bits dropped [RULE_07]
        ADDR_NEN: nen_nxt = PWDATA[NSRC-1:0];
        ADDR_FEN: fen_nxt = PWDATA[NSRC-1:0];
        ADDR_MASK: mask_nxt = PWDATA[NSRC-1:0];
        default: ;
      endcase
    end
    // Only bits actually reported in the snapshot are cleared
    if (acc_rd && PADDR == ADDR_STAT)
      stat_nxt = stat_r & ~rdat_r[NSRC-1:0];
    stat_nxt = stat_nxt | events;
    // Read data captured in the setup cycle
    if (setup && !PWRITE)
    begin
      unique case (PADDR)
        ADDR_TRIG: rdat_nxt = {20'h00000, trig_r};
        ADDR_CLR: rdat_nxt = clr_word(sif.pend);
        ADDR_NEN: rdat_nxt = {26'h0000000, nen_r};
        ADDR_FEN: rdat_nxt = {26'h0000000, fen_r};
        ADDR_STAT: rdat_nxt = {26'h0000000, stat_r};
        ADDR_MASK: rdat_nxt = {26'h0000000, mask_r};
        ADDR_SRC: rdat_nxt = {18'h00000, sif.cond, 2'h0, sif.samp};
        default: rdat_nxt = WORD_RST;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      trig_r <= TRIG_RST;
      nen_r <= EN_RST;
      fen_r <= EN_RST;
      mask_r <= EN_RST;
      stat_r <= EN_RST;
      rdat_r <= WORD_RST;
      cond_q_r <= EN_RST;
    end
    else
    begin
      trig_r <= trig_nxt;
      nen_r <= nen_nxt;
      fen_r <= fen_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      rdat_r <= rdat_nxt;
      cond_q_r <= cond_q_nxt;
    end
  end

  // Requests to the vectored controller, gated by enables [RULE_14]
  always_comb
  begin
    irq_nxt = sif.cond & nen_r;
    fiq_nxt = sif.cond & fen_r;
    int_nxt = |(stat_r & mask_r);
  end

  // Registered so the controller sees glitch-free requests, at one cycle cost
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      irq_r <= EN_RST;
      fiq_r <= EN_RST;
      int_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
      fiq_r <= fiq_nxt;
      int_r <= int_nxt;
    end
  end

  assign IRQ_REQ = irq_r;
  assign FIQ_REQ = fiq_r;
  assign INT_OUT = int_r;

  property p_gate_irq;
    @(posedge MCLK) disable iff (SRST)
    ##1 ((IRQ_REQ & ~$past(nen_r)) == 6'h00) && ((FIQ_REQ & ~$past(fen_r)) == 6'h00);
  endproperty
  a_gate_irq: assert property (p_gate_irq) else $error("request passed while disabled"); // [RULE_14]

  property p_req_follow;
    @(posedge MCLK) disable iff (SRST)
    (sif.cond[0] && nen_r[0]) |=> IRQ_REQ[0];
  endproperty
  a_req_follow: assert property (p_req_follow) else $error("enabled request not sent"); // [RULE_14]

  // A clear only wins when no edge is seen in the same cycle, hence the stable guard
  sequence s_clr_la1;
    acc_wr && PADDR == ADDR_CLR && PWDATA[CLR_HI_POS+4] && trig_r[11];
  endsequence

  property p_clr_la1;
    @(posedge MCLK) disable iff (SRST)
    (s_clr_la1 and $stable(sif.samp[5])) |=> !sif.pend[5];
  endproperty
  a_clr_la1: assert property (p_clr_la1) else $error("pending not cleared by write"); // [RULE_13]

  sequence s_clr_ext0;
    acc_wr && PADDR == ADDR_CLR && PWDATA[CLR_EXT0_POS] && trig_r[1];
  endsequence

  property p_clr_ext0;
    @(posedge MCLK) disable iff (SRST)
    (s_clr_ext0 and (sif.pend[0] && $stable(sif.samp[0]))) |=> !sif.pend[0];
  endproperty
  a_clr_ext0: assert property (p_clr_ext0) else $error("ext0 pending not cleared"); // [RULE_08]

  property p_int_out;
    @(posedge MCLK) disable iff (SRST)
    (|(events & mask_r)) ##1 (mask_r == $past(mask_r)) |=> INT_OUT;
  endproperty
  a_int_out: assert property (p_int_out) else $error("masked event did not interrupt");

  // Remaining clear bits, one per source, each checked apart so a swapped bit shows
  sequence s_clr_ext1;
    acc_wr && PADDR == ADDR_CLR && PWDATA[CLR_HI_POS] && trig_r[3];
  endsequence

  property p_clr_ext1;
    @(posedge MCLK) disable iff (SRST)
    (s_clr_ext1 and $stable(sif.samp[1])) |=> !sif.pend[1];
  endproperty
  a_clr_ext1: assert property (p_clr_ext1) else $error("ext1 pending not cleared"); // [RULE_09]

  sequence s_clr_la0;
    acc_wr && PADDR == ADDR_CLR && PWDATA[CLR_HI_POS+1] && trig_r[5];
  endsequence

  property p_clr_la0;
    @(posedge MCLK) disable iff (SRST)
    (s_clr_la0 and $stable(sif.samp[2])) |=> !sif.pend[2];
  endproperty
  a_clr_la0: assert property (p_clr_la0) else $error("la0 pending not cleared"); // [RULE_10]

  sequence s_clr_ext2;
    acc_wr && PADDR == ADDR_CLR && PWDATA[CLR_HI_POS+2] && trig_r[7];
  endsequence

  property p_clr_ext2;
    @(posedge MCLK) disable iff (SRST)
    (s_clr_ext2 and $stable(sif.samp[3])) |=> !sif.pend[3];
  endproperty
  a_clr_ext2: assert property (p_clr_ext2) else $error("ext2 pending not cleared"); // [RULE_11]

  sequence s_clr_ext3;
    acc_wr && PADDR == ADDR_CLR && PWDATA[CLR_HI_POS+3] && trig_r[9];
  endsequence

  property p_clr_ext3;
    @(posedge MCLK) disable iff (SRST)
    (s_clr_ext3 and $stable(sif.samp[4])) |=> !sif.pend[4];
  endproperty
  a_clr_ext3: assert property (p_clr_ext3) else $error("ext3 pending not cleared"); // [RULE_12]

  // Mode decoding seen from the register side, so a field swap inside the conditioner shows
  property p_lvl_ext0;
    @(posedge MCLK) disable iff (SRST)
    (trig_r[1:0] == MODE_HIGH) |-> (sif.cond[0] == sif.samp[0]);
  endproperty
  a_lvl_ext0: assert property (p_lvl_ext0) else $error("ext0 high level not followed"); // [RULE_01]

  property p_low_ext1;
    @(posedge MCLK) disable iff (SRST)
    (trig_r[3:2] == MODE_LOW) |-> (sif.cond[1] != sif.samp[1]);
  endproperty
  a_low_ext1: assert property (p_low_ext1) else $error("ext1 low level not followed"); // [RULE_02]

  property p_fall_ext2;
    @(posedge MCLK) disable iff (SRST)
    (trig_r[7:6] == MODE_FALL && $fell(sif.samp[3])) |=> sif.pend[3];
  endproperty
  a_fall_ext2: assert property (p_fall_ext2) else $error("ext2 falling edge missed"); // [RULE_04]

  property p_no_rise_ext2;
    @(posedge MCLK) disable iff (SRST)
    (trig_r[7:6] == MODE_FALL && !sif.pend[3] && !$fell(sif.samp[3])) |=> !sif.pend[3];
  endproperty
  a_no_rise_ext2: assert property (p_no_rise_ext2) else $error("ext2 set without fall"); // [RULE_04]

  property p_rise_ext3;
    @(posedge MCLK) disable iff (SRST)
    (trig_r[9:8] == MODE_RISE && $rose(sif.samp[4])) |=> sif.pend[4];
  endproperty
  a_rise_ext3: assert property (p_rise_ext3) else $error("ext3 rising edge missed"); // [RULE_05]

  property p_fall_la1;
    @(posedge MCLK) disable iff (SRST)
    (trig_r[11:10] == MODE_FALL && $fell(sif.samp[5])) |=> sif.pend[5];
  endproperty
  a_fall_la1: assert property (p_fall_la1) else $error("la1 falling edge missed"); // [RULE_06]

  // Synchroniser depth is two edges once reset has been gone that long
  property p_sync;
    @(posedge MCLK) disable iff (SRST)
    (!$past(SRST) && !$past(SRST, 2)) |-> (sif.samp == $past(sif.src, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("source sample depth wrong"); // [RULE_15]

  property p_hold_ext0;
    @(posedge MCLK) disable iff (SRST)
    (sif.pend[0] && !sif.clr[0] && trig_r[1]) |=> sif.pend[0];
  endproperty
  a_hold_ext0: assert property (p_hold_ext0) else $error("ext0 pending lost"); // [RULE_15]

  property p_lvl_nopend;
    @(posedge MCLK) disable iff (SRST)
    !trig_r[9] |=> !sif.pend[4];
  endproperty
  a_lvl_nopend: assert property (p_lvl_nopend) else $error("ext3 level mode latched"); // [RULE_16]

  // Register side: trigger write keeps only the used field, stray writes change nothing
  property p_trig_wr;
    @(posedge MCLK) disable iff (SRST)
    (acc_wr && PADDR == ADDR_TRIG) |=> (trig_r == $past(PWDATA[TRIG_USED-1:0]));
  endproperty
  a_trig_wr: assert property (p_trig_wr) else $error("trigger write not stored"); // [RULE_01]

  property p_unmapped;
    @(posedge MCLK) disable iff (SRST)
    (acc_wr && !mapped) |=> ($stable(trig_r) && $stable(nen_r) && $stable(fen_r) && $stable(mask_r));
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed a register");

  // Status is cleared by the read that reported it, and a fresh event is never lost
  property p_stat_clr;
    @(posedge MCLK) disable iff (SRST)
    (acc_rd && PADDR == ADDR_STAT && events == 6'h00) |=> ((stat_r & $past(rdat_r[NSRC-1:0])) == 6'h00);
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status not cleared by read");

  property p_stat_set;
    @(posedge MCLK) disable iff (SRST)
    (|events) |=> ((stat_r & $past(events)) == $past(events));
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status event lost");
endmodule
`default_nettype wire

// ### logic/etc_pkg.sv
// Shared constants for the external interrupt trigger conditioner
package etc_pkg;
  localparam int NSRC = 6;
  localparam int TRIG_W = 2;
  // Register byte addresses
  localparam logic [31:0] ADDR_TRIG = 32'hffff0034;
  localparam logic [31:0] ADDR_CLR = 32'hffff0038;
  localparam logic [31:0] ADDR_NEN = 32'hffff0050;
  localparam logic [31:0] ADDR_FEN = 32'hffff0054;
  localparam logic [31:0] ADDR_STAT = 32'hffff0058;
  localparam logic [31:0] ADDR_MASK = 32'hffff005c;
  localparam logic [31:0] ADDR_SRC = 32'hffff0060;
  // Field layout
  localparam int TRIG_USED = 12;
  localparam int CLR_EXT0_POS = 13;
  localparam int CLR_HI_POS = 16;
  localparam int SRC_COND_POS = 8;
  // Trigger encodings per two-bit field
  localparam logic [1:0] MODE_HIGH = 2'h0;
  localparam logic [1:0] MODE_LOW = 2'h1;
  localparam logic [1:0] MODE_RISE = 2'h2;
  localparam logic [1:0] MODE_FALL = 2'h3;
  // Reset values
  localparam logic [11:0] TRIG_RST = 12'h000;
  localparam logic [5:0] EN_RST = 6'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Pick the six clear bits out of a written word
  function automatic logic [5:0] clr_bits(input logic [31:0] w);
    clr_bits = {w[CLR_HI_POS+4:CLR_HI_POS], w[CLR_EXT0_POS]};
  endfunction

  // Place six per-source flags at their clear-bit positions
  function automatic logic [31:0] clr_word(input logic [5:0] p);
    clr_word = WORD_RST;
    clr_word[CLR_EXT0_POS] = p[0];
    clr_word[CLR_HI_POS+4:CLR_HI_POS] = p[5:1];
  endfunction
endpackage

// ### logic/etc_src_if.sv
// Signals between the register side and the source conditioner
`timescale 1ns/1ns
`default_nettype none
interface etc_src_if;
  logic [11:0] sel;
  logic [5:0] clr;
  logic [5:0] src;
  logic [5:0] samp;
  logic [5:0] pend;
  logic [5:0] cond;
  modport ctl (output sel, output clr, output src, input samp, input pend, input cond);
  modport cnd (input sel, input clr, input src, output samp, output pend, output cond);
endinterface
`default_nettype wire

// ### logic/etc_cond.sv
// Per-source synchroniser, edge detector and pending flags
`timescale 1ns/1ns
`default_nettype none
module etc_cond
(
  input wire logic clk,
  input wire logic rst,
  etc_src_if.cnd cp
);
  import etc_pkg::*;

  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [5:0] s3_r;
  logic [5:0] pend_r;
  logic [5:0] pend_nxt;
  logic [5:0] fall;
  logic [5:0] rise;

  // Two-flop synchroniser, third stage only keeps the previous sample [RULE_15]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      s3_r <= 6'h00;
    end
    else
    begin
      s1_r <= cp.src;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign fall = s3_r & ~s2_r;
  assign rise = ~s3_r & s2_r;
  assign cp.samp = s2_r;
  assign cp.pend = pend_r;

  // Decode each two-bit field; set beats clear so no edge is lost
  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      logic [1:0] m;
      m = cp.sel[TRIG_W*i +: TRIG_W];
      pend_nxt[i] = 1'b0;
      cp.cond[i] = 1'b0;
      unique case (m) // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_06]
        MODE_FALL: pend_nxt[i] = fall[i] | (pend_r[i] & ~cp.clr[i]); // [RULE_15]
        MODE_RISE: pend_nxt[i] = rise[i] | (pend_r[i] & ~cp.clr[i]); // [RULE_15]
        MODE_LOW: cp.cond[i] = ~s2_r[i]; // [RULE_16]
        MODE_HIGH: cp.cond[i] = s2_r[i]; // [RULE_16]
      endcase
      if (m[1])
        cp.cond[i] = pend_r[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pend_r <= 6'h00;
    else
      pend_r <= pend_nxt;
  end

  property p_fall_pend;
    @(posedge clk) disable iff (rst)
    (cp.sel[1:0] == MODE_FALL && fall[0]) |=> pend_r[0];
  endproperty
  a_fall_pend: assert property (p_fall_pend) else $error("falling edge not latched"); // [RULE_01]

  property p_rise_pend;
    @(posedge clk) disable iff (rst)
    (cp.sel[5:4] == MODE_RISE && rise[2]) |=> pend_r[2] ##0 cp.cond[2];
  endproperty
  a_rise_pend: assert property (p_rise_pend) else $error("rising edge not latched"); // [RULE_03]

  property p_low_lvl;
    @(posedge clk) disable iff (rst)
    (cp.sel[3:2] == MODE_LOW && !cp.src[1]) ##1 (cp.sel[3:2] == MODE_LOW && !cp.src[1])
      |=> cp.cond[1];
  endproperty
  a_low_lvl: assert property (p_low_lvl) else $error("low level request missing"); // [RULE_02]

  property p_hold;
    @(posedge clk) disable iff (rst)
    (pend_r[4] && !cp.clr[4] && cp.sel[9]) |=> pend_r[4];
  endproperty
  a_hold: assert property (p_hold) else $error("pending dropped without clear"); // [RULE_15]

  property p_no_pend_lvl;
    @(posedge clk) disable iff (rst)
    (cp.sel[7:6] == MODE_HIGH) |=> !pend_r[3];
  endproperty
  a_no_pend_lvl: assert property (p_no_pend_lvl) else $error("level mode latched"); // [RULE_16]
endmodule
`default_nettype wire

// ### bench/etc_pin_model.sv
// Model of the external interrupt pins and logic-array request lines
`timescale 1ns/1ns
`default_nettype none
module etc_pin_model
(
  input wire logic clk,
  input wire logic [5:0] want,
  output logic [3:0] ext_pin,
  output logic [1:0] la_req
);
  // Idle low from time zero so the synchroniser never starts on an unknown
  initial
  begin
    ext_pin = 4'h0;
    la_req = 2'h0;
  end
  // Lines move only after a core edge, like logic-array outputs; source order as the block's
  always @(posedge clk)
  begin
    ext_pin <= {want[4], want[3], want[1], want[0]};
    la_req <= {want[5], want[2]};
  end
endmodule
`default_nettype wire

// ### bench/ext_irq_trigger_conditioner_tb_top.sv
// Self-checking bench for the trigger conditioner
`timescale 1ns/1ns
`default_nettype none
module ext_irq_trigger_conditioner_tb_top;
  import etc_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] pins = 6'h00;
  logic [3:0] ext_int;
  logic [1:0] la_int;
  logic [5:0] irq_req;
  logic [5:0] fiq_req;
  logic int_out;
  logic [31:0] rd;
  logic er;
  logic [11:0] mode;
  logic [5:0] lvl, edg, nen, fen, msk, clr;
  logic [31:0] regs [6] = '{ADDR_TRIG, ADDR_CLR, ADDR_NEN, ADDR_FEN, ADDR_STAT, ADDR_MASK};
  int n_errors = 0;
  int total_checks = 0;
  integer seed = 32'h40d1;

  always #25 mclk = ~mclk;

  etc_top u_dut (.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_INT(ext_int), .LA_INT(la_int), .IRQ_REQ(irq_req), .FIQ_REQ(fiq_req),
    .INT_OUT(int_out));
  etc_pin_model u_pins (.clk(mclk), .want(pins), .ext_pin(ext_int), .la_req(la_int));

  // Own bit placement of the clear and pending-readback word
  function automatic logic [31:0] to_clr(input logic [5:0] p);
    to_clr = {11'h0, p[5:1], 2'h0, p[0], 13'h0};
  endfunction

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No wait count assumed here; only the watchdog ends a hung access
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Settle past the edge so registered outputs are read after they update
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 32'h0, rd, er);
      chk(rd, WORD_RST);
    end
    // Unmapped place is refused both ways
    apb(1'b1, 32'hffff0044, 32'hffffffff, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 32'hffff0044, 32'h0, rd, er);
    chk({30'h0, er, rd[0]}, 32'h2);
    // First four passes set one code on every source, the rest are random mixes
    for (int it = 0; it < 12; it++)
    begin
      for (int s = 0; s < 6; s++)
      begin
        mode[2*s +: 2] = (it < 4) ? 2'(it) : 2'($random(seed));
        lvl[s] = mode[2*s];
        edg[s] = mode[2*s+1];
      end
      nen = 6'($random(seed));
      fen = 6'($random(seed));
      msk = 6'($random(seed));
      clr = 6'($random(seed));
      apb(1'b1, ADDR_TRIG, {20'h0, mode}, rd, er);
      apb(1'b1, ADDR_NEN, {26'h0, nen}, rd, er);
      apb(1'b1, ADDR_FEN, {26'h0, fen}, rd, er);
      apb(1'b1, ADDR_MASK, {26'h0, msk}, rd, er);
      pins <= lvl;
      cyc(8);
      apb(1'b1, ADDR_CLR, to_clr(6'h3f), rd, er);
      apb(1'b0, ADDR_STAT, 32'h0, rd, er);
      cyc(3);
      chk({25'h0, int_out, irq_req}, 32'h0);
      apb(1'b0, ADDR_TRIG, 32'h0, rd, er);
      chk(rd, {20'h0, mode});
      pins <= ~lvl;
      cyc(8);
      chk({20'h0, fiq_req, irq_req}, {20'h0, fen, nen});
      chk({31'h0, int_out}, {31'h0, |msk});
      apb(1'b0, ADDR_SRC, 32'h0, rd, er);
      chk(rd, {18'h0, 6'h3f, 2'h0, ~lvl});
      apb(1'b0, ADDR_STAT, 32'h0, rd, er);
      chk(rd, 32'h3f);
      apb(1'b1, ADDR_CLR, to_clr(clr), rd, er);
      cyc(3);
      chk({25'h0, int_out, irq_req}, {26'h0, nen & ~(edg & clr)});
      pins <= lvl;
      cyc(8);
      chk({26'h0, irq_req}, {26'h0, nen & edg & ~clr});
      apb(1'b0, ADDR_CLR, 32'h0, rd, er);
      chk(rd, to_clr(edg & ~clr));
    end
    give_verdict;
  end

  // Whole run is near 790 cycles; some 25 times that means a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
